// >>> design/indirect_address_and_alu_flags.sv
// indirect pointer registers with access ports, working register and alu flags
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module indirect_address_and_alu_flags (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [11:0] memAddr,
    output logic memRead,
    output logic memWrite,
    output logic [7:0] memWdata,
    input wire logic [7:0] memRdata,
    input wire logic aluValid,
    input wire logic [2:0] aluOp,
    input wire logic [7:0] aluA,
    input wire logic [7:0] aluB,
    input wire logic aluToFlags,
    output logic [7:0] aluResult,
    output logic [7:0] flagsOut
);
    ind_addr_pkg::state_e state;
    ind_addr_pkg::state_e next_state;
    logic [7:0] working_register;
    logic [ind_addr_pkg::FLAGS_W-1:0] flags;
    logic [ind_addr_pkg::FLAGS_W-1:0] next_flags;
    logic [11:0] ptrVal [0:ind_addr_pkg::NUM_PTR-1];

    pointer_if ptrBus [0:ind_addr_pkg::NUM_PTR-1] ();

    // apb decode
    logic apbAccess;
    logic [4:0] apbIdx;
    logic apbMapped;
    logic indirect;
    assign apbAccess = psel & penable;
    assign apbIdx = paddr[6:ind_addr_pkg::APB_IDX_LSB];
    assign apbMapped = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'h0)
        && (apbIdx <= ind_addr_pkg::IDX_LAST);
    assign indirect = apbMapped && (apbIdx >= ind_addr_pkg::IDX_VPORT_BASE);

    // which pointer and which of its five ports
    logic [4:0] vIdx;
    logic [1:0] ptrSel;
    logic [4:0] modeWide;
    logic [2:0] mode;
    assign vIdx = apbIdx - ind_addr_pkg::IDX_VPORT_BASE;
    assign ptrSel = (vIdx >= 5'h0A) ? 2'h2 : (vIdx >= ind_addr_pkg::MODES_PER_PTR) ? 2'h1 : 2'h0;
    assign modeWide = vIdx - ((ptrSel == 2'h2) ? 5'h0A :
        (ptrSel == 2'h1) ? ind_addr_pkg::MODES_PER_PTR : 5'h00);
    assign mode = modeWide[2:0];

    // effective address
    logic [11:0] selPtr;
    logic [11:0] offset;
    logic [11:0] target;
    assign selPtr = ptrVal[ptrSel];
    assign offset = {{4{working_register[7]}}, working_register};
    assign target = (mode == ind_addr_pkg::MODE_PREINC) ? selPtr + 12'h001 :
        (mode == ind_addr_pkg::MODE_INDEXED) ? selPtr + offset :
        selPtr;

    // where the access lands
    logic targetLocal;
    logic [4:0] targetIdx;
    logic targetMapped;
    logic toMemory;
    logic [4:0] regIdx;
    logic regValid;
    logic selfRef;
    logic regAccess;
    assign targetLocal = target[11:5] == ind_addr_pkg::FILE_BASE[11:5];
    assign targetIdx = target[4:0];
    assign targetMapped = targetLocal && (targetIdx <= ind_addr_pkg::IDX_LAST);
    assign toMemory = indirect && !targetLocal;
    assign regIdx = indirect ? targetIdx : apbIdx;
    assign regValid = indirect ? targetMapped : apbMapped;
    assign selfRef = indirect && targetMapped
        && (targetIdx >= ind_addr_pkg::IDX_VPORT_BASE);
    assign regAccess = regValid && !selfRef;

    // register read view
    logic [11:0] byteSrc;
    logic [7:0] ptrByte;
    logic [7:0] regRdata;
    assign byteSrc = ptrVal[regIdx[2:1]];
    assign ptrByte = regIdx[0] ? {4'h0, byteSrc[11:8]} : byteSrc[7:0];
    assign regRdata = (regIdx < ind_addr_pkg::IDX_WORKING_REGISTER) ? ptrByte :
        (regIdx == ind_addr_pkg::IDX_WORKING_REGISTER) ? working_register :
        (regIdx == ind_addr_pkg::IDX_FLAGS) ? {3'h0, flags} :
        8'h00;

    // completion of an apb transfer; register writes, pointer steps and the self-reference zero flag take place here
    logic commit;
    logic regWrite;
    assign pready = (state == ind_addr_pkg::ST_DONE) && ce;
    assign pslverr = pready && !apbMapped;
    assign commit = apbAccess && pready;
    assign regWrite = commit && pwrite && regAccess;

    logic stepInc;
    logic stepDec;
    assign stepInc = commit && indirect
        && (mode == ind_addr_pkg::MODE_POSTINC || mode == ind_addr_pkg::MODE_PREINC);
    assign stepDec = commit && indirect && (mode == ind_addr_pkg::MODE_POSTDEC);

    for (genvar g = 0; g < ind_addr_pkg::NUM_PTR; g++) begin : gPtr
        assign ptrBus[g].loadLow = regWrite && (regIdx == 5'(2 * g));
        assign ptrBus[g].loadHigh = regWrite && (regIdx == 5'(2 * g + 1));
        assign ptrBus[g].loadData = pwdata[7:0];
        assign ptrBus[g].stepUp = stepInc && (ptrSel == 2'(g));
        assign ptrBus[g].stepDown = stepDec && (ptrSel == 2'(g));
        assign ptrVal[g] = ptrBus[g].value;
        pointer_reg uPtr (
            .mclk(mclk),
            .srst(srst),
            .ce(ce),
            .ptr(ptrBus[g])
        );
    end

    // alu result and flag logic
    logic isSub;
    logic [7:0] bOperand;
    logic [8:0] sum;
    logic [4:0] nibSum;
    logic [7:0] aluRes;
    logic [ind_addr_pkg::FLAGS_W-1:0] aluNew;
    logic [ind_addr_pkg::FLAGS_W-1:0] aluMask;
    logic ovf;
    assign isSub = aluOp == ind_addr_pkg::ALU_SUB;
    // subtraction adds the two's complement, so carries act as inverted borrows
    assign bOperand = isSub ? ~aluB : aluB;
    assign sum = {1'b0, aluA} + {1'b0, bOperand} + {8'h00, isSub};
    assign nibSum = {1'b0, aluA[3:0]} + {1'b0, bOperand[3:0]} + {4'h0, isSub};
    assign ovf = (aluA[7] == bOperand[7]) && (sum[7] != aluA[7]);
    assign aluRes = (aluOp == ind_addr_pkg::ALU_ROTL) ? {aluA[6:0], flags[ind_addr_pkg::FLAG_C]} :
        (aluOp == ind_addr_pkg::ALU_ROTR) ? {flags[ind_addr_pkg::FLAG_C], aluA[7:1]} :
        (aluOp == ind_addr_pkg::ALU_LOGIC) ? aluA :
        sum[7:0];
    assign aluNew[ind_addr_pkg::FLAG_N] = aluRes[7];
    assign aluNew[ind_addr_pkg::FLAG_OV] = ovf;
    assign aluNew[ind_addr_pkg::FLAG_Z] = aluRes == 8'h00;
    assign aluNew[ind_addr_pkg::FLAG_DC] = (aluOp == ind_addr_pkg::ALU_ROTL) ? aluA[3] :
        (aluOp == ind_addr_pkg::ALU_ROTR) ? aluA[4] : nibSum[4];
    assign aluNew[ind_addr_pkg::FLAG_C] = (aluOp == ind_addr_pkg::ALU_ROTL) ? aluA[7] :
        (aluOp == ind_addr_pkg::ALU_ROTR) ? aluA[0] : sum[8];
    assign aluMask = (aluOp == ind_addr_pkg::ALU_ROTL || aluOp == ind_addr_pkg::ALU_ROTR) ?
        ind_addr_pkg::MASK_ROTATE : (aluOp == ind_addr_pkg::ALU_LOGIC) ?
        ind_addr_pkg::MASK_LOGIC : ind_addr_pkg::MASK_ARITH;

    // flag next value: software write, then self-reference zero, then alu on top
    logic flagsWrite;
    logic zeroSet;
    logic [ind_addr_pkg::FLAGS_W-1:0] swFlags;
    logic [ind_addr_pkg::FLAGS_W-1:0] baseFlags;
    assign flagsWrite = regWrite && (regIdx == ind_addr_pkg::IDX_FLAGS);
    assign zeroSet = commit && !pwrite && selfRef;
    assign swFlags = flagsWrite ? pwdata[4:0] : flags;
    // a masked destination write keeps only the bits the operation leaves alone
    assign baseFlags = (aluValid && aluToFlags) ? aluRes[4:0] :
        (zeroSet ? (swFlags | 5'h04) : swFlags);
    assign next_flags = aluValid ? ((baseFlags & ~aluMask) | (aluNew & aluMask)) : baseFlags;
    assign flagsOut = {3'h0, flags};

    always_ff @(posedge mclk) begin
        if (srst) begin
            flags <= ind_addr_pkg::FLAGS_RESET;
        end else if (ce) begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            aluResult <= 8'h00;
        end else if (ce && aluValid) begin
            aluResult <= aluRes;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            working_register <= ind_addr_pkg::WORKING_REGISTER_RESET;
        end else if (ce && regWrite && regIdx == ind_addr_pkg::IDX_WORKING_REGISTER) begin
            working_register <= pwdata[7:0];
        end
    end

    // transfer sequencer
    always_comb begin
        case (state)
            ind_addr_pkg::ST_IDLE: begin
                if (apbAccess) begin
                    next_state = toMemory ? ind_addr_pkg::ST_MEM : ind_addr_pkg::ST_DONE;
                end else begin
                    next_state = ind_addr_pkg::ST_IDLE;
                end
            end
            ind_addr_pkg::ST_MEM: next_state = ind_addr_pkg::ST_CAP;
            ind_addr_pkg::ST_CAP: next_state = ind_addr_pkg::ST_DONE;
            ind_addr_pkg::ST_DONE: next_state = ind_addr_pkg::ST_IDLE;
            default: next_state = ind_addr_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= ind_addr_pkg::ST_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    logic startMem;
    logic startReg;
    assign startMem = (state == ind_addr_pkg::ST_IDLE) && apbAccess && toMemory;
    assign startReg = (state == ind_addr_pkg::ST_IDLE) && apbAccess && !toMemory;

    always_ff @(posedge mclk) begin
        if (srst) begin
            memAddr <= 12'h000;
            memWdata <= 8'h00;
            memRead <= 1'b0;
            memWrite <= 1'b0;
        end else if (ce) begin
            memRead <= startMem && !pwrite;
            memWrite <= startMem && pwrite;
            if (startMem) begin
                memAddr <= target;
                memWdata <= pwdata[7:0];
            end
        end
    end

    // read data: register view, zero for self reference, or the memory byte
    always_ff @(posedge mclk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (ce && startReg) begin
            prdata <= {24'h00_0000, regAccess ? regRdata : 8'h00};
        end else if (ce && state == ind_addr_pkg::ST_CAP) begin
            prdata <= {24'h00_0000, memRdata};
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    AST_POSTINC: assert property (commit && indirect && ptrSel == 2'h0
        && mode == ind_addr_pkg::MODE_POSTINC && !ptrBus[0].loadLow && !ptrBus[0].loadHigh
        |=> ptrVal[0] == $past(ptrVal[0]) + 12'h001) else $error("post-increment missed");
    AST_POSTDEC: assert property (commit && indirect && ptrSel == 2'h1
        && mode == ind_addr_pkg::MODE_POSTDEC && !ptrBus[1].loadLow && !ptrBus[1].loadHigh
        |=> ptrVal[1] == $past(ptrVal[1]) - 12'h001) else $error("post-decrement missed");
    AST_PREINC_STEP: assert property (commit && indirect && ptrSel == 2'h0
        && mode == ind_addr_pkg::MODE_PREINC && !ptrBus[0].loadLow && !ptrBus[0].loadHigh
        |=> ptrVal[0] == $past(ptrVal[0]) + 12'h001) else $error("pre-increment step missed");
    AST_PREINC_ADDR: assert property (ce && startMem
        && mode == ind_addr_pkg::MODE_PREINC
        |=> memAddr == $past(selPtr) + 12'h001) else $error("pre-increment address wrong");
    AST_PLAIN_ADDR: assert property (ce && startMem && mode == ind_addr_pkg::MODE_PLAIN
        |=> memAddr == $past(selPtr)) else $error("plain port address wrong");
    AST_INDEXED_HOLD: assert property (commit && indirect
        && mode == ind_addr_pkg::MODE_INDEXED && !regWrite
        |=> ptrVal[$past(ptrSel)] == $past(selPtr)) else $error("indexed moved pointer");
    AST_WORKING_REGISTER_HOLD: assert property (commit && indirect
        && mode == ind_addr_pkg::MODE_INDEXED && !regWrite
        |=> $stable(working_register)) else $error("indexed changed working register");
    AST_STEP_NO_FLAGS: assert property (commit && (stepInc || stepDec)
        && !aluValid && !flagsWrite && !zeroSet
        |=> $stable(flags)) else $error("pointer step changed flags");
    AST_MEM_ROUTE: assert property (ce && startMem && !pwrite
        |=> memRead && !memWrite ##1 (!memRead || !$past(ce)))
        else $error("memory read not issued once");
    AST_SELF_READ: assert property (ce && startReg && selfRef && !pwrite
        |=> prdata == 32'h0000_0000) else $error("self read not zero");
    AST_SELF_ZERO: assert property (zeroSet && !aluValid
        |=> flags[ind_addr_pkg::FLAG_Z]) else $error("self read left zero flag clear");
    AST_SELF_WRITE: assert property (commit && pwrite && selfRef && !aluValid
        |=> $stable(flags) && $stable(working_register)) else $error("self write changed state");
    AST_HIGH_NIBBLE: assert property (ce && startReg && regAccess && regIdx[0]
        && regIdx < ind_addr_pkg::IDX_WORKING_REGISTER
        |=> prdata[7:4] == 4'h0) else $error("high byte top set");
    AST_CE_FREEZE: assert property (!ce |=> $stable(flags) && $stable(working_register) && $stable(state)
        && $stable(prdata) && $stable(aluResult) && $stable(ptrVal[0]) && $stable(ptrVal[1])
        && $stable(ptrVal[2])) else $error("state moved with clock enable low");
    AST_ZERO_NEG: assert property (ce && aluValid
        |=> flags[ind_addr_pkg::FLAG_Z] == (aluResult == 8'h00)
        && flags[ind_addr_pkg::FLAG_N] == aluResult[7]) else $error("zero or negative wrong");
    AST_ADD_CARRY: assert property (ce && aluValid && aluOp == ind_addr_pkg::ALU_ADD
        |=> flags[ind_addr_pkg::FLAG_C] == $past(sum[8])) else $error("add carry wrong");
    AST_OVERFLOW: assert property (ce && aluValid && aluOp == ind_addr_pkg::ALU_ADD
        |=> flags[ind_addr_pkg::FLAG_OV] == ($past(aluA[7]) == $past(aluB[7])
        && aluResult[7] != $past(aluA[7]))) else $error("add overflow wrong");
    AST_DIGIT_ADD: assert property (ce && aluValid && aluOp == ind_addr_pkg::ALU_ADD
        |=> flags[ind_addr_pkg::FLAG_DC] == ({1'b0, $past(aluA[3:0])}
        + {1'b0, $past(aluB[3:0])} > 5'h0F)) else $error("add digit carry wrong");
    AST_SUB_BORROW: assert property (ce && aluValid
        && aluOp == ind_addr_pkg::ALU_SUB
        |=> flags[ind_addr_pkg::FLAG_C] == ($past(aluA) >= $past(aluB))
        && flags[ind_addr_pkg::FLAG_DC] == ($past(aluA[3:0]) >= $past(aluB[3:0])))
        else $error("subtract borrow wrong");
    AST_ROTL_CARRY: assert property (ce && aluValid
        && aluOp == ind_addr_pkg::ALU_ROTL
        |=> flags[ind_addr_pkg::FLAG_C] == $past(aluA[7])
        && flags[ind_addr_pkg::FLAG_DC] == $past(aluA[3])
        && aluResult[0] == $past(flags[ind_addr_pkg::FLAG_C]))
        else $error("rotate left wrong");
    AST_ROTR_CARRY: assert property (ce && aluValid
        && aluOp == ind_addr_pkg::ALU_ROTR
        |=> flags[ind_addr_pkg::FLAG_C] == $past(aluA[0])
        && flags[ind_addr_pkg::FLAG_DC] == $past(aluA[4])
        && aluResult[7] == $past(flags[ind_addr_pkg::FLAG_C]))
        else $error("rotate right wrong");
    AST_MASK_WRITE: assert property (ce && aluValid && aluToFlags
        && aluOp == ind_addr_pkg::ALU_LOGIC
        |=> flags[ind_addr_pkg::FLAG_C] == $past(aluA[0])) else $error("unaffected flag lost");
    AST_LOGIC_KEEP: assert property (ce && aluValid && !aluToFlags && !flagsWrite
        && aluOp == ind_addr_pkg::ALU_LOGIC
        |=> flags[ind_addr_pkg::FLAG_C] == $past(flags[ind_addr_pkg::FLAG_C])
        && flags[ind_addr_pkg::FLAG_DC] == $past(flags[ind_addr_pkg::FLAG_DC])
        && flags[ind_addr_pkg::FLAG_OV] == $past(flags[ind_addr_pkg::FLAG_OV]))
        else $error("logic result touched carry flags");
    AST_FLAGS_TOP: assert property (flagsOut[7:5] == 3'h0) else $error("flag top bits set");

    COV_MEM_READ: cover property (commit && toMemory && !pwrite);
    COV_SELF_REF: cover property (commit && selfRef);
    COV_PTR_OWN_WRITE: cover property (regWrite && indirect && (stepInc || stepDec));
    COV_ALU_TO_FLAGS: cover property (ce && aluValid && aluToFlags);
endmodule
`default_nettype wire

// >>> design/ind_addr_pkg.sv
// constants, encodings and register map for the indirect pointer and alu flag block
package ind_addr_pkg;
    localparam int PTR_W = 12;
    localparam int DATA_W = 8;
    localparam int NUM_PTR = 3;
    localparam int FLAGS_W = 5;

    // file addresses of the block's own registers: FILE_BASE + index
    localparam logic [11:0] FILE_BASE = 12'hFE0;
    // apb byte address = index * 4
    localparam int APB_IDX_LSB = 2;
    localparam logic [4:0] IDX_PTR_BASE = 5'h00;
    localparam logic [4:0] IDX_WORKING_REGISTER = 5'h06;
    localparam logic [4:0] IDX_FLAGS = 5'h07;
    localparam logic [4:0] IDX_VPORT_BASE = 5'h08;
    localparam logic [4:0] IDX_LAST = 5'h16;
    localparam logic [4:0] MODES_PER_PTR = 5'h05;

    // access modes, in order within each pointer's group of five ports
    localparam logic [2:0] MODE_PLAIN = 3'h0;
    localparam logic [2:0] MODE_POSTDEC = 3'h1;
    localparam logic [2:0] MODE_POSTINC = 3'h2;
    localparam logic [2:0] MODE_PREINC = 3'h3;
    localparam logic [2:0] MODE_INDEXED = 3'h4;

    // alu_flags field positions
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;

    localparam logic [FLAGS_W-1:0] MASK_ARITH = 5'h1F;
    localparam logic [FLAGS_W-1:0] MASK_ROTATE = 5'h17;
    localparam logic [FLAGS_W-1:0] MASK_LOGIC = 5'h14;

    localparam logic [PTR_W-1:0] PTR_RESET = 12'h000;
    localparam logic [DATA_W-1:0] WORKING_REGISTER_RESET = 8'h00;
    localparam logic [FLAGS_W-1:0] FLAGS_RESET = 5'h00;

    typedef enum logic [2:0] {
        ALU_ADD = 3'h0,
        ALU_SUB = 3'h1,
        ALU_ROTL = 3'h2,
        ALU_ROTR = 3'h3,
        ALU_LOGIC = 3'h4
    } alu_op_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_MEM = 4'h2,
        ST_CAP = 4'h4,
        ST_DONE = 4'h8
    } state_e;
endpackage

// >>> design/pointer_if.sv
// load and step controls of one pointer register, and its value
`timescale 1ns/10ps
`default_nettype none
interface pointer_if;
    logic [ind_addr_pkg::PTR_W-1:0] value;
    logic loadLow;
    logic loadHigh;
    logic [ind_addr_pkg::DATA_W-1:0] loadData;
    logic stepUp;
    logic stepDown;
    modport owner(input loadLow, input loadHigh, input loadData, input stepUp,
        input stepDown, output value);
    modport user(output loadLow, output loadHigh, output loadData, output stepUp,
        output stepDown, input value);
endinterface
`default_nettype wire

// >>> design/pointer_reg.sv
// one 12-bit pointer built from a low byte and a four-bit high byte
`timescale 1ns/10ps
`default_nettype none
module pointer_reg (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    pointer_if.owner ptr
);
    logic [ind_addr_pkg::PTR_W-1:0] value;
    logic [ind_addr_pkg::PTR_W-1:0] next_value;
    logic [ind_addr_pkg::PTR_W-1:0] loaded;

    assign ptr.value = value;
    assign loaded = {ptr.loadHigh ? ptr.loadData[3:0] : value[11:8],
        ptr.loadLow ? ptr.loadData : value[7:0]};
    // a byte write drops the step entirely; stepping spans all 12 bits
    assign next_value = (ptr.loadLow | ptr.loadHigh) ? loaded :
        ptr.stepUp ? value + 12'h001 :
        ptr.stepDown ? value - 12'h001 :
        value;

    always_ff @(posedge mclk) begin
        if (srst) begin
            value <= ind_addr_pkg::PTR_RESET;
        end else if (ce) begin
            value <= next_value;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    AST_LOAD_WINS: assert property (ce && ptr.loadLow && (ptr.stepUp || ptr.stepDown)
        |=> value[7:0] == $past(ptr.loadData)) else $error("step overrode byte write");
    AST_CARRY_HIGH: assert property (ce && ptr.stepUp && !ptr.loadLow && !ptr.loadHigh
        && value[7:0] == 8'hFF |=> value[11:8] == $past(value[11:8]) + 4'h1)
        else $error("low byte overflow did not carry");
    COV_WRAP: cover property (ce && ptr.stepDown && value == 12'h000);
endmodule
`default_nettype wire

// >>> verification/data_ram_model.sv
// synchronous data ram standing behind the indirect addressing block
`timescale 1ns/10ps
`default_nettype none
module data_ram_model (
    input wire logic mclk,
    input wire logic [11:0] memAddr,
    input wire logic memRead,
    input wire logic memWrite,
    input wire logic [7:0] memWdata,
    output logic [7:0] memRdata
);
    logic [7:0] mem [4096];
    logic [7:0] lastRd;
    logic rdValid;
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = i[7:0] ^ 8'h5A;
        end
        lastRd = 8'h00;
        rdValid = 1'h0;
    end
    // one byte per address across the full 12-bit space
    always @(posedge mclk) begin
        if (memWrite) begin
            mem[memAddr] <= memWdata;
        end
        if (memRead) begin
            lastRd <= mem[memAddr];
        end
        rdValid <= memRead;
    end
    // data is only good the cycle after a read; otherwise show a changed value
    assign memRdata = rdValid ? lastRd : ~lastRd;
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the indirect pointer and alu flag block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic mclk, srst, ce, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, memAddr;
    logic [31:0] pwdata, prdata, rdv;
    logic memRead, memWrite, aluValid, aluToFlags, er;
    logic [7:0] memWdata, memRdata, aluA, aluB, aluResult, flagsOut;
    logic [2:0] aluOp;
    int errors, nCompared;

    indirect_address_and_alu_flags dut (.mclk(mclk), .srst(srst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .memAddr(memAddr),
        .memRead(memRead), .memWrite(memWrite), .memWdata(memWdata),
        .memRdata(memRdata), .aluValid(aluValid), .aluOp(aluOp), .aluA(aluA),
        .aluB(aluB), .aluToFlags(aluToFlags), .aluResult(aluResult), .flagsOut(flagsOut));
    data_ram_model ram (.mclk(mclk), .memAddr(memAddr), .memRead(memRead),
        .memWrite(memWrite), .memWdata(memWdata), .memRdata(memRdata));

    initial begin
        mclk = 1'h0;
        forever #10 mclk = ~mclk;
    end

    task give_verdict;
        $display("compared %0d mismatches %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one apb transfer; pready, read data and error are taken at one rising edge
    task apb(input logic w, input logic [4:0] idx, input logic [7:0] wd,
        output logic [31:0] rd, output logic err);
        int n;
        @(posedge mclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= {5'h00, idx, 2'h0};
        pwdata <= {24'h000000, wd};
        @(posedge mclk);
        penable <= 1'h1;
        for (n = 0; n < 100; n++) begin
            @(posedge mclk);
            if (pready === 1'h1) break;
        end
        if (n == 100) begin
            errors++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task wr(input logic [4:0] idx, input logic [7:0] d);
        apb(1'h1, idx, d, rdv, er);
    endtask

    task rdk(input logic [4:0] idx, input logic [7:0] exp);
        apb(1'h0, idx, 8'h00, rdv, er);
        chk(rdv, {24'h000000, exp});
        chk(er, 32'h0);
    endtask

    task alu(input logic [2:0] op, input logic [7:0] a, input logic [7:0] b,
        input logic tf, input logic [7:0] res, input logic [7:0] fl);
        @(posedge mclk);
        aluValid <= 1'h1;
        aluOp <= op;
        aluA <= a;
        aluB <= b;
        aluToFlags <= tf;
        @(posedge mclk);
        aluValid <= 1'h0;
        aluToFlags <= 1'h0;
        @(negedge mclk);
        chk(aluResult, res);
        chk(flagsOut, fl);
    endtask

    task t_reset;
        rdk(5'h07, 8'h00);
        rdk(5'h06, 8'h00);
        rdk(5'h01, 8'h00);
    endtask

    task t_regs;
        wr(5'h01, 8'hFF);
        rdk(5'h01, 8'h0F);
        wr(5'h07, 8'hFF);
        rdk(5'h07, 8'h1F);
        apb(1'h0, 5'h17, 8'h00, rdv, er);
        chk(er, 32'h1);
        chk(rdv, 32'h0);
        apb(1'h1, 5'h17, 8'h33, rdv, er);
        chk(er, 32'h1);
    endtask

    task t_modes;
        wr(5'h00, 8'hFF);
        wr(5'h01, 8'h00);
        wr(5'h0A, 8'hA5);
        rdk(5'h00, 8'h00);
        rdk(5'h01, 8'h01);
        wr(5'h09, 8'h3C);
        rdk(5'h00, 8'hFF);
        rdk(5'h01, 8'h00);
        rdk(5'h0B, 8'h3C);
        rdk(5'h00, 8'h00);
        wr(5'h06, 8'hFF);
        rdk(5'h0C, 8'hA5);
        rdk(5'h00, 8'h00);
        rdk(5'h06, 8'hFF);
        rdk(5'h08, 8'h3C);
    endtask

    task t_selfref;
        wr(5'h02, 8'hE8);
        wr(5'h03, 8'h0F);
        wr(5'h07, 8'h00);
        rdk(5'h0D, 8'h00);
        rdk(5'h07, 8'h04);
        wr(5'h07, 8'h01);
        wr(5'h0D, 8'h77);
        rdk(5'h07, 8'h01);
    endtask

    task t_own;
        wr(5'h00, 8'hE0);
        wr(5'h01, 8'h0F);
        wr(5'h0A, 8'h55);
        rdk(5'h00, 8'h55);
        rdk(5'h01, 8'h0F);
    endtask

    task t_stepzero;
        wr(5'h04, 8'h01);
        wr(5'h05, 8'h00);
        wr(5'h07, 8'h00);
        rdk(5'h13, 8'h5B);
        rdk(5'h04, 8'h00);
        rdk(5'h07, 8'h00);
    endtask

    task t_alu;
        alu(ind_addr_pkg::ALU_ADD, 8'h7F, 8'h01, 1'h0, 8'h80, 8'h1A);
        alu(ind_addr_pkg::ALU_ADD, 8'hFF, 8'h01, 1'h0, 8'h00, 8'h07);
        alu(ind_addr_pkg::ALU_SUB, 8'h05, 8'h05, 1'h0, 8'h00, 8'h07);
        alu(ind_addr_pkg::ALU_SUB, 8'h00, 8'h01, 1'h0, 8'hFF, 8'h10);
        alu(ind_addr_pkg::ALU_ROTL, 8'h98, 8'h00, 1'h0, 8'h30, 8'h03);
        alu(ind_addr_pkg::ALU_ROTR, 8'h19, 8'h00, 1'h0, 8'h8C, 8'h13);
        alu(ind_addr_pkg::ALU_LOGIC, 8'h00, 8'h00, 1'h0, 8'h00, 8'h07);
        alu(ind_addr_pkg::ALU_ADD, 8'h80, 8'h80, 1'h1, 8'h00, 8'h0D);
        alu(ind_addr_pkg::ALU_LOGIC, 8'h0B, 8'h00, 1'h1, 8'h0B, 8'h0B);
        rdk(5'h07, 8'h0B);
    endtask

    // clock enable low: an alu pulse must leave result and flags alone
    task t_freeze;
        @(posedge mclk);
        ce <= 1'h0;
        alu(ind_addr_pkg::ALU_ADD, 8'h01, 8'h01, 1'h0, 8'h0B, 8'h0B);
        @(posedge mclk);
        ce <= 1'h1;
        rdk(5'h07, 8'h0B);
    endtask

    initial begin
        errors = 0;
        nCompared = 0;
        srst = 1'h1;
        ce = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        aluValid = 1'h0;
        aluOp = 3'h0;
        aluA = 8'h00;
        aluB = 8'h00;
        aluToFlags = 1'h0;
        repeat (6) @(posedge mclk);
        srst <= 1'h0;
        t_reset();
        t_regs();
        t_modes();
        t_selfref();
        t_own();
        t_stepzero();
        t_alu();
        t_freeze();
        give_verdict();
    end
endmodule
`default_nettype wire
